// >>> core/watchdog_map.svh
// Purpose: Named offsets, bit positions, reset values and counts of the watchdog
// Assumes: Included by its bare name from every watchdog file except the package
// Notes: Definitions only
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_RELOAD 8'h00
`define ADDR_INT_EN_ZERO 8'h01
`define ADDR_INT_EN_ONE 8'h02
`define ADDR_PRIO_STATUS 8'h03
`define ADDR_CLK_CTL 8'h04
`define ADDR_STATUS 8'h05
`define ADDR_COUNT_LO 8'h06
`define ADDR_COUNT_HI 8'h07

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_PRESCALE 7
`define BIT_ARM 6
`define BIT_CONFIRM 6
`define BIT_TIMEOUT 6
`define BIT_SCOPE 7
`define BIT_ST_ACTIVE 0
`define BIT_ST_ARMED 1
`define BIT_ST_CONFIRM 2
`define BIT_ST_TIMEOUT 3

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define RESET_BYTE 8'h00
`define COUNT_ZERO 15'h0000
`define COUNT_TERMINAL 15'h7ffc
`define RELOAD_LOW_FILL 8'h00
`define DIV_FAST 24
`define DIV_SLOW 384
`define REFRESH_WINDOW 12

`endif

// >>> core/watchdog_pkg.sv
// Purpose: Types shared by the watchdog files
// Assumes: Nothing
// Notes: Arming states follow a Gray cycle
package watchdog_pkg;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_ARMED = 2'b11,
    ST_OFF_ARMED = 2'b10
  } wdog_state_t;

endpackage

// >>> core/watchdog_prescaler.sv
// Purpose: Divides the CPU clock into counting ticks
// Assumes: Reset already synchronised
// Notes: Divider restarts whenever the watchdog is not running
`timescale 1ns/1ps
`include "watchdog_map.svh"

module watchdog_prescaler #(
  parameter int unsigned DIV_FAST = `DIV_FAST,
  parameter int unsigned DIV_SLOW = `DIV_SLOW
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic slow_i,
  output logic tick_o
);

  localparam int unsigned CW = $clog2(DIV_SLOW);

  if (DIV_FAST < 2 || DIV_SLOW <= DIV_FAST) begin : g_bad_div
    $error("prescaler divisors unusable");
  end

  logic [CW-1:0] div_reg;
  logic [CW-1:0] term;

  assign term = slow_i ? CW'(DIV_SLOW - 1) : CW'(DIV_FAST - 1);
  assign tick_o = run_i && (div_reg == term);

  // Divide by 24 or 384
  // Using >= keeps a select change mid-period from running past the end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
    end else if (!run_i || div_reg >= term) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  a_tick_gap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tick_o |=> !tick_o)
    else $error("ticks back to back");

endmodule

// >>> core/watchdog_refresh_timer.sv
// Purpose: Watchdog with two-step refresh and CPU reset request
// Assumes: Register strobes come from logic on core_clk_i
// Notes: Only arst_n_i (pin or power reset) stops a running watchdog
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "watchdog_map.svh"

// Operation
// - A 15-bit up-counter, a 7-bit reload value and control logic form the watchdog.
// - After pin or power reset the watchdog is off and its counter is zero.
// - Software starts it by setting confirm, with or without a preceding arm, and afterwards nothing but a hardware reset stops it.
// - While running the counter steps every 384 CPU clocks with prescale select set, else every 24.
// - Reaching 7FFC hex raises the timeout and requests a CPU reset.
// - A refresh is an arm write followed by a confirm write within 12 cycles.
// - If no confirm arrives within 12 cycles the arm bit clears itself and nothing reloads.
// - A valid refresh loads the reload value into the top seven counter bits.
// - Setting confirm activates or refreshes, and confirm clears itself 12 cycles after it is set.
// - The timeout flag is read-only at bit 6 of the priority register and clears after the CPU reset.
// - With the scope bit set a watchdog reset also resets peripheral registers but not clock control.
module watchdog_refresh_timer
  import watchdog_pkg::*;
#(
  parameter int unsigned REFRESH_WIN = `REFRESH_WINDOW,
  parameter int unsigned DIV_FAST = `DIV_FAST,
  parameter int unsigned DIV_SLOW = `DIV_SLOW
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  input wire logic cpu_rst_done_i,
  output logic cpu_rst_req_o,
  output logic periph_rst_o
);

  localparam int unsigned WW = $clog2(REFRESH_WIN + 1);

  if (REFRESH_WIN < 1 || REFRESH_WIN > 255) begin : g_bad_win
    $error("refresh window unusable");
  end

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic wr_reload;
  logic wr_en_zero;
  logic wr_en_one;
  logic wr_prio;
  logic wr_clk_ctl;
  logic arm_wr;
  logic conf_wr;

  assign wr_reload = we_i && (addr_i == `ADDR_RELOAD);
  assign wr_en_zero = we_i && (addr_i == `ADDR_INT_EN_ZERO);
  assign wr_en_one = we_i && (addr_i == `ADDR_INT_EN_ONE);
  assign wr_prio = we_i && (addr_i == `ADDR_PRIO_STATUS);
  assign wr_clk_ctl = we_i && (addr_i == `ADDR_CLK_CTL);
  assign arm_wr = wr_en_zero && wdata_i[`BIT_ARM];
  assign conf_wr = wr_en_one && wdata_i[`BIT_CONFIRM];

  // ****************************************************************
  // Arming state
  // ****************************************************************
  wdog_state_t state_reg;
  wdog_state_t state_next;
  logic [WW-1:0] arm_cnt_reg;
  logic [WW-1:0] conf_cnt_reg;
  logic arm_expire;
  logic refresh_hit;
  logic active;
  logic armed;
  logic conf_bit;

  assign arm_expire = (arm_cnt_reg == WW'(1));
  assign active = state_reg[0];
  assign armed = state_reg[1];
  assign conf_bit = (conf_cnt_reg != '0);

  always_comb begin
    state_next = state_reg;
    refresh_hit = 1'b0;
    unique case (state_reg)
      ST_OFF: begin
        if (conf_wr) begin
          state_next = ST_RUN;
        end else if (arm_wr) begin
          state_next = ST_OFF_ARMED;
        end
      end
      ST_OFF_ARMED: begin
        if (conf_wr) begin
          state_next = ST_RUN;
          refresh_hit = 1'b1;
        end else if (arm_wr) begin
          state_next = ST_OFF_ARMED;
        end else if (arm_expire) begin
          state_next = ST_OFF;
        end
      end
      ST_RUN: begin
        if (arm_wr) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (conf_wr) begin
          state_next = ST_RUN;
          refresh_hit = 1'b1;
        end else if (arm_wr) begin
          state_next = ST_ARMED;
        end else if (arm_expire) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Arm window count
  // A fresh arm restarts the window, so the set wins over the self-clear
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arm_cnt_reg <= '0;
    end else if (arm_wr) begin
      arm_cnt_reg <= WW'(REFRESH_WIN);
    end else if (conf_wr && armed) begin
      arm_cnt_reg <= '0;
    end else if (arm_cnt_reg != '0) begin
      arm_cnt_reg <= arm_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      conf_cnt_reg <= '0;
    end else if (conf_wr) begin
      conf_cnt_reg <= WW'(REFRESH_WIN);
    end else if (conf_cnt_reg != '0) begin
      conf_cnt_reg <= conf_cnt_reg - 1'b1;
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  logic [7:0] reload_reg;
  logic [14:0] count_reg;
  logic tick;
  logic timeout_evt;

  watchdog_prescaler #(
    .DIV_FAST(DIV_FAST),
    .DIV_SLOW(DIV_SLOW)
  ) u_prescaler (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .run_i(active),
    .slow_i(reload_reg[`BIT_PRESCALE]),
    .tick_o(tick)
  );

  assign timeout_evt = tick && !refresh_hit && (count_reg == `COUNT_TERMINAL - 15'h0001);

  // Fifteen-bit up-counter
  // Restarting from zero after the terminal value avoids a silent wrap
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `COUNT_ZERO;
    end else if (refresh_hit) begin
      count_reg <= {reload_reg[6:0], `RELOAD_LOW_FILL};
    end else if (tick) begin
      if (count_reg == `COUNT_TERMINAL) begin
        count_reg <= `COUNT_ZERO;
      end else begin
        count_reg <= count_reg + 15'h0001;
      end
    end
  end

  // ****************************************************************
  // Timeout and reset requests
  // ****************************************************************
  logic flag_reg;
  logic clk_scope;
  logic scope_rst;

  // Cleared by the completed CPU reset, set wins
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (timeout_evt) begin
      flag_reg <= 1'b1;
    end else if (cpu_rst_done_i) begin
      flag_reg <= 1'b0;
    end
  end

  assign scope_rst = timeout_evt && clk_scope;
  assign cpu_rst_req_o = flag_reg;
  assign periph_rst_o = flag_reg && clk_scope;

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [7:0] en_zero_reg;
  logic [7:0] en_one_reg;
  logic [7:0] prio_reg;
  logic [7:0] clk_ctl_reg;

  assign clk_scope = clk_ctl_reg[`BIT_SCOPE];

  // Peripheral registers follow the scope reset
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reload_reg <= `RESET_BYTE;
    end else if (scope_rst) begin
      reload_reg <= `RESET_BYTE;
    end else if (wr_reload) begin
      reload_reg <= wdata_i;
    end
  end

  // Arm and confirm bits live in the state logic, not here
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_zero_reg <= `RESET_BYTE;
    end else if (scope_rst) begin
      en_zero_reg <= `RESET_BYTE;
    end else if (wr_en_zero) begin
      en_zero_reg <= wdata_i;
      en_zero_reg[`BIT_ARM] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_one_reg <= `RESET_BYTE;
    end else if (scope_rst) begin
      en_one_reg <= `RESET_BYTE;
    end else if (wr_en_one) begin
      en_one_reg <= wdata_i;
      en_one_reg[`BIT_CONFIRM] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prio_reg <= `RESET_BYTE;
    end else if (scope_rst) begin
      prio_reg <= `RESET_BYTE;
    end else if (wr_prio) begin
      prio_reg <= wdata_i;
      prio_reg[`BIT_TIMEOUT] <= 1'b0;
    end
  end

  // Clock control kept across watchdog reset
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctl_reg <= `RESET_BYTE;
    end else if (wr_clk_ctl) begin
      clk_ctl_reg <= wdata_i;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = `RESET_BYTE;
    unique case (addr_i)
      `ADDR_RELOAD: begin
        rd_mux = reload_reg;
      end
      `ADDR_INT_EN_ZERO: begin
        rd_mux = en_zero_reg;
        rd_mux[`BIT_ARM] = armed;
      end
      `ADDR_INT_EN_ONE: begin
        rd_mux = en_one_reg;
        rd_mux[`BIT_CONFIRM] = conf_bit;
      end
      `ADDR_PRIO_STATUS: begin
        rd_mux = prio_reg;
        rd_mux[`BIT_TIMEOUT] = flag_reg;
      end
      `ADDR_CLK_CTL: begin
        rd_mux = clk_ctl_reg;
      end
      `ADDR_STATUS: begin
        rd_mux[`BIT_ST_ACTIVE] = active;
        rd_mux[`BIT_ST_ARMED] = armed;
        rd_mux[`BIT_ST_CONFIRM] = conf_bit;
        rd_mux[`BIT_ST_TIMEOUT] = flag_reg;
      end
      `ADDR_COUNT_LO: begin
        rd_mux = count_reg[7:0];
      end
      `ADDR_COUNT_HI: begin
        rd_mux = {1'b0, count_reg[14:8]};
      end
      default: begin
        rd_mux = `RESET_BYTE;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= `RESET_BYTE;
    end else if (re_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= `RESET_BYTE;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_arm_quiet_12;
    arm_wr ##1 (!conf_wr && !arm_wr)[*8] ##1 (!conf_wr && !arm_wr)[*4];
  endsequence

  sequence s_arm_quiet_9;
    arm_wr ##1 (!conf_wr && !arm_wr)[*8];
  endsequence

  sequence s_conf_quiet_12;
    conf_wr ##1 (!conf_wr)[*8] ##1 (!conf_wr)[*4];
  endsequence

  a_arm_expiry: assert property (s_arm_quiet_12 |=> !armed)
    else $error("arm bit outlived its window");

  a_arm_holds: assert property (s_arm_quiet_9 |=> armed)
    else $error("arm bit cleared early");

  a_refresh_load: assert property (refresh_hit |=>
    count_reg == {$past(reload_reg[6:0]), `RELOAD_LOW_FILL})
    else $error("refresh did not reload counter");

  a_confirm_hold: assert property (conf_wr |=> conf_bit[*8])
    else $error("confirm bit cleared early");

  a_confirm_clear: assert property (s_conf_quiet_12 |=> !conf_bit)
    else $error("confirm bit did not self-clear");

  a_stay_active: assert property (active |=> active)
    else $error("watchdog stopped while active");

  a_off_zero: assert property (!active |-> count_reg == `COUNT_ZERO)
    else $error("counter moved while off");

  a_count_hold: assert property (active && !tick && !refresh_hit |=> $stable(count_reg))
    else $error("counter moved without a tick");

  a_timeout_set: assert property (timeout_evt |=>
    flag_reg && cpu_rst_req_o && count_reg == `COUNT_TERMINAL)
    else $error("terminal value without timeout");

  a_flag_clear: assert property (flag_reg && cpu_rst_done_i && !timeout_evt |=> !flag_reg)
    else $error("timeout flag not cleared");

  a_flag_read: assert property (re_i && addr_i == `ADDR_PRIO_STATUS |=>
    rdata_o[`BIT_TIMEOUT] == $past(flag_reg))
    else $error("timeout flag read wrong");

  a_scope_reset: assert property (periph_rst_o |-> cpu_rst_req_o && clk_ctl_reg[`BIT_SCOPE])
    else $error("peripheral reset out of scope");

endmodule

// >>> bench/tb.sv
// Purpose: Self-checking bench for the watchdog refresh timer
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: Slow divider shortened so the slow rate shows in a few dozen cycles
`timescale 1ns/1ps
`include "watchdog_map.svh"

module tb;
  // ****************************************************************
  // Settings and signals
  // ****************************************************************
  localparam int unsigned SLOW_DIV = 40;
  localparam logic [7:0] ARM_B = 8'h01 << `BIT_ARM;
  localparam logic [7:0] CONF_B = 8'h01 << `BIT_CONFIRM;
  localparam logic [7:0] FLAG_B = 8'h01 << `BIT_TIMEOUT;
  localparam int TIMEOUT_CYC = int'(`COUNT_TERMINAL - 15'h7f00) * `DIV_FAST;
  localparam logic [7:0] ROW_A [10] = '{`ADDR_RELOAD, `ADDR_INT_EN_ZERO, `ADDR_INT_EN_ONE, `ADDR_PRIO_STATUS,
    `ADDR_CLK_CTL, `ADDR_STATUS, `ADDR_COUNT_LO, `ADDR_COUNT_HI, 8'h08, 8'hff};
  localparam logic [7:0] ROW_D [10] = '{8'ha5, 8'h3f, 8'h95, 8'hff, 8'h5a, 8'hff, 8'hff, 8'hff, 8'h77, 8'h77};
  localparam logic [7:0] ROW_E [10] = '{8'ha5, 8'h3f, 8'h95, 8'hbf, 8'h5a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  logic core_clk;
  logic arst_n;
  logic we;
  logic re;
  logic rst_done;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic cpu_rst_req;
  logic periph_rst;
  int error_cnt;
  int comparisons;

  watchdog_refresh_timer #(
    .REFRESH_WIN(`REFRESH_WINDOW),
    .DIV_FAST(`DIV_FAST),
    .DIV_SLOW(SLOW_DIV)
  ) dut_u (
    .core_clk_i(core_clk),
    .arst_n_i(arst_n),
    .addr_i(addr),
    .wdata_i(wdata),
    .we_i(we),
    .re_i(re),
    .rdata_o(rdata),
    .cpu_rst_done_i(rst_done),
    .cpu_rst_req_o(cpu_rst_req),
    .periph_rst_o(periph_rst)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    we <= 1'b0;
  endtask

  // Second write is taken k edges after the first
  task automatic wr_pair(input logic [7:0] a1, input logic [7:0] d1, input logic [7:0] a2, input logic [7:0] d2,
                         input int k);
    @(posedge core_clk);
    we <= 1'b1;
    addr <= a1;
    wdata <= d1;
    if (k > 1) begin
      @(posedge core_clk);
      we <= 1'b0;
      repeat (k - 2) @(posedge core_clk);
    end
    @(posedge core_clk);
    we <= 1'b1;
    addr <= a2;
    wdata <= d2;
    @(posedge core_clk);
    we <= 1'b0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    re <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    re <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  // Confirm alone starts from zero; counts sampled mid-period to tolerate divider phase
  task automatic act_rate(input logic [7:0] rel, input logic [7:0] e1, input logic [7:0] e2);
    do_reset();
    wr(`ADDR_RELOAD, rel);
    wr(`ADDR_INT_EN_ONE, CONF_B);
    rd_chk(`ADDR_INT_EN_ONE, CONF_B);
    rd_chk(`ADDR_STATUS, 8'h05);
    rd_chk(`ADDR_COUNT_LO, 8'h00);
    repeat (26) @(posedge core_clk);
    rd_chk(`ADDR_COUNT_LO, e1);
    repeat (22) @(posedge core_clk);
    rd_chk(`ADDR_COUNT_LO, e2);
    rd_chk(`ADDR_INT_EN_ONE, 8'h00);
    rd_chk(`ADDR_COUNT_HI, 8'h00);
    wr(`ADDR_INT_EN_ZERO, 8'h00);
    wr(`ADDR_INT_EN_ONE, 8'h00);
    wr(`ADDR_STATUS, 8'h00);
    rd_chk(`ADDR_STATUS, 8'h01);
    $display("done: activation and rate %h", rel);
  endtask

  task automatic run_timeout(input logic [7:0] scope, input logic [7:0] prio);
    int cyc;
    cyc = 0;
    do_reset();
    wr(`ADDR_CLK_CTL, scope);
    wr(`ADDR_PRIO_STATUS, prio);
    wr(`ADDR_RELOAD, 8'h7f);
    wr_pair(`ADDR_INT_EN_ZERO, ARM_B, `ADDR_INT_EN_ONE, CONF_B, 1);
    while (cpu_rst_req !== 1'b1 && cyc < TIMEOUT_CYC + 200) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    chk(16'((cyc > TIMEOUT_CYC - 12) && (cyc < TIMEOUT_CYC + 12)), 16'h0001);
    chk({15'h0000, periph_rst}, {15'h0000, scope[`BIT_SCOPE]});
    rd_chk(`ADDR_PRIO_STATUS, scope[`BIT_SCOPE] ? FLAG_B : (prio | FLAG_B));
    rd_chk(`ADDR_RELOAD, scope[`BIT_SCOPE] ? 8'h00 : 8'h7f);
    rd_chk(`ADDR_CLK_CTL, scope);
    rd_chk(`ADDR_STATUS, 8'h09);
    @(posedge core_clk);
    rst_done <= 1'b1;
    @(posedge core_clk);
    rst_done <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({14'h0000, cpu_rst_req, periph_rst}, 16'h0000);
    rd_chk(`ADDR_STATUS, 8'h01);
    $display("done: timeout with scope %h", scope);
  endtask

  task automatic end_sim;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog on the bench itself
  // ****************************************************************
  initial begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    end_sim();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    we = 1'b0;
    re = 1'b0;
    rst_done = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    error_cnt = 0;
    comparisons = 0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      rd_chk(ROW_A[i], 8'h00);
      wr(ROW_A[i], ROW_D[i]);
      rd_chk(ROW_A[i], ROW_E[i]);
    end
    $display("done: register rows");
    act_rate(8'h05, 8'h01, 8'h02);
    act_rate(8'h80, 8'h00, 8'h01);
    // Window edges: last accepted gap, first refused gap, back to back
    do_reset();
    wr(`ADDR_INT_EN_ZERO, ARM_B);
    rd_chk(`ADDR_INT_EN_ZERO, ARM_B);
    repeat (12) @(posedge core_clk);
    rd_chk(`ADDR_INT_EN_ZERO, 8'h00);
    wr(`ADDR_RELOAD, 8'h05);
    wr_pair(`ADDR_INT_EN_ZERO, ARM_B, `ADDR_INT_EN_ONE, CONF_B, `REFRESH_WINDOW);
    rd_chk(`ADDR_COUNT_HI, 8'h05);
    wr(`ADDR_RELOAD, 8'h0a);
    wr_pair(`ADDR_INT_EN_ZERO, ARM_B, `ADDR_INT_EN_ONE, CONF_B, `REFRESH_WINDOW + 1);
    rd_chk(`ADDR_COUNT_HI, 8'h05);
    rd_chk(`ADDR_INT_EN_ZERO, 8'h00);
    wr_pair(`ADDR_INT_EN_ZERO, ARM_B, `ADDR_INT_EN_ONE, CONF_B, 1);
    rd_chk(`ADDR_COUNT_HI, 8'h0a);
    $display("done: refresh window");
    // Refreshes spaced inside the timeout span; a re-arm restarts the window
    do_reset();
    wr(`ADDR_RELOAD, 8'h7f);
    wr_pair(`ADDR_INT_EN_ZERO, ARM_B, `ADDR_INT_EN_ONE, CONF_B, 1);
    for (int n = 0; n < 3; n++) begin
      repeat (TIMEOUT_CYC / 2) @(posedge core_clk);
      wr(`ADDR_RELOAD, 8'(8'h7c + n));
      wr(`ADDR_INT_EN_ZERO, ARM_B);
      repeat (6) @(posedge core_clk);
      wr_pair(`ADDR_INT_EN_ZERO, ARM_B, `ADDR_INT_EN_ONE, CONF_B, 8);
      rd_chk(`ADDR_COUNT_HI, 8'(8'h7c + n));
    end
    repeat (TIMEOUT_CYC / 2) @(posedge core_clk);
    #1;
    chk({15'h0000, cpu_rst_req}, 16'h0000);
    $display("done: regular refresh");
    run_timeout(8'h80, 8'h2a);
    run_timeout(8'h00, 8'h2a);
    end_sim();
  end
endmodule
